// ### pkg/esf_pkg.sv
// Constants, types and transaction decode of the external snoop filter
//
// Functional notes
// - Allocating reads and uniques mark line held
// - Non-allocating transactions leave tracking unchanged
// - Evicting transactions and writebacks drop the line
// - Watch every allocating and evicting transaction
// - Error responses do not alter tracking
// - Snoop response IsShared decides line retention
// - Non-snooping accesses are never tracked
// - Lookup before insert, no duplicate entries
// - Storage covers every line cache holds
// - Extra ways track in-flight or other lines
// - Full set triggers own CleanInvalid back-snoop
`default_nettype none

package esf_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W     = 32;
  localparam int LINE_OFS   = 6;
  localparam int CACHE_SETS = 256;
  localparam int CACHE_WAYS = 4;
  localparam int EXTRA_WAYS = 1;

  // ==========================================================
  // Snoop response layout
  localparam int RESP_W       = 5;
  localparam int ISSHARED_BIT = 3;
  localparam logic [4:0] RESP_MISS = 5'h00;

  // ==========================================================
  // Read-side codes (4 bits) and write-side codes (3 bits)
  localparam logic [3:0] RD_NOSNOOP_ONCE = 4'h0;
  localparam logic [3:0] RD_SHARED       = 4'h1;
  localparam logic [3:0] RD_CLEAN        = 4'h2;
  localparam logic [3:0] RD_NOTSHDIRTY   = 4'h3;
  localparam logic [3:0] RD_UNIQUE       = 4'h7;
  localparam logic [3:0] CLEAN_SHARED    = 4'h8;
  localparam logic [3:0] CLEAN_INVALID   = 4'h9;
  localparam logic [3:0] CLEAN_UNIQUE    = 4'hb;
  localparam logic [3:0] MAKE_UNIQUE     = 4'hc;
  localparam logic [3:0] MAKE_INVALID    = 4'hd;
  localparam logic [2:0] WR_NOSNOOP_UNIQUE = 3'h0;
  localparam logic [2:0] WR_LINE_UNIQUE    = 3'h1;
  localparam logic [2:0] WR_CLEAN          = 3'h2;
  localparam logic [2:0] WR_BACK           = 3'h3;
  localparam logic [2:0] WR_EVICT_ONLY     = 3'h4;
  localparam logic [2:0] WR_EVICT          = 3'h5;
  localparam logic [1:0] DOM_NONSH = 2'h0;
  localparam logic [1:0] DOM_SYS   = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {K_NONE, K_KEEP, K_ALLOC, K_EVICT} esf_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOK, ST_FWD, ST_WAIT, ST_RESP, ST_VFWD, ST_VWAIT
  } esf_state_t;

  // Response status is not an input: tracking ignores errors
  function automatic esf_kind_t esf_classify(input logic       isWrite,
                                             input logic [3:0] code,
                                             input logic [1:0] dom);
    logic      noSnoop;
    esf_kind_t k;
    noSnoop = (dom == DOM_NONSH) || (dom == DOM_SYS);
    k = K_KEEP;
    if (isWrite) begin
      case (code[2:0])
        WR_NOSNOOP_UNIQUE: k = noSnoop ? K_NONE : K_KEEP;
        WR_LINE_UNIQUE:    k = K_KEEP;
        WR_CLEAN:          k = K_KEEP;
        WR_BACK:           k = K_EVICT;
        WR_EVICT_ONLY:     k = K_EVICT;
        WR_EVICT:          k = K_EVICT;
        default:           k = K_KEEP;
      endcase
    end else begin
      case (code)
        RD_NOSNOOP_ONCE: k = noSnoop ? K_NONE : K_KEEP;
        RD_SHARED:       k = K_ALLOC;
        RD_CLEAN:        k = K_ALLOC;
        RD_NOTSHDIRTY:   k = K_ALLOC;
        RD_UNIQUE:       k = K_ALLOC;
        CLEAN_UNIQUE:    k = K_ALLOC;
        MAKE_UNIQUE:     k = K_ALLOC;
        CLEAN_SHARED:    k = K_KEEP;
        CLEAN_INVALID:   k = K_EVICT;
        MAKE_INVALID:    k = K_EVICT;
        default:         k = K_KEEP;
      endcase
    end
    return k;
  endfunction

endpackage

`default_nettype wire

// ### pkg/esf_tag_if.sv
// Lookup and write port between filter control and its tag store
`default_nettype none

interface esf_tag_if #(
  parameter int IDXW = 8,
  parameter int TAGW = 18,
  parameter int WAYW = 3
) ();
  logic [IDXW-1:0] lkSet;
  logic [TAGW-1:0] lkTag;
  logic            hit;
  logic [WAYW-1:0] hitWay;
  logic            freeValid;
  logic [WAYW-1:0] freeWay;
  logic [WAYW-1:0] rdWay;
  logic [TAGW-1:0] rdTag;
  logic            wrEn;
  logic [WAYW-1:0] wrWay;
  logic            wrValid;
  logic [TAGW-1:0] wrTag;

  modport store (
    input  lkSet, lkTag, rdWay, wrEn, wrWay, wrValid, wrTag,
    output hit, hitWay, freeValid, freeWay, rdTag
  );
  modport ctrl (
    output lkSet, lkTag, rdWay, wrEn, wrWay, wrValid, wrTag,
    input  hit, hitWay, freeValid, freeWay, rdTag
  );
endinterface

`default_nettype wire

// ### hw/esf_tag_store.sv
// Set-associative tag store holding the lines the master may hold
`default_nettype none

module esf_tag_store import esf_pkg::*; #(
  parameter int SETS  = CACHE_SETS,
  parameter int NWAYS = CACHE_WAYS + EXTRA_WAYS,
  parameter int TAGW  = 18,
  parameter int WAYW  = 3
) (
  input wire logic   clk,
  input wire logic   rst_n,
  input wire logic   en,
  esf_tag_if.store   tg
);

  // ==========================================================
  // Storage sized to the cache plus spare ways
  logic [NWAYS-1:0] valid [SETS];
  logic [TAGW-1:0]  tags  [SETS][NWAYS];
  logic [NWAYS-1:0] hitVec;

  // ==========================================================
  // Compare all ways of the addressed set
  for (genvar w = 0; w < NWAYS; w++) begin : g_way
    assign hitVec[w] = valid[tg.lkSet][w] && (tags[tg.lkSet][w] == tg.lkTag);
  end

  always_comb begin
    tg.hit       = 1'b0;
    tg.hitWay    = '0;
    tg.freeValid = 1'b0;
    tg.freeWay   = '0;
    for (int w = NWAYS - 1; w >= 0; w--) begin
      if (hitVec[w]) begin
        tg.hit    = 1'b1;
        tg.hitWay = WAYW'(w);
      end
      if (!valid[tg.lkSet][w]) begin
        tg.freeValid = 1'b1;
        tg.freeWay   = WAYW'(w);
      end
    end
  end

  assign tg.rdTag = tags[tg.lkSet][tg.rdWay];

  // ==========================================================
  // Write port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < SETS; s++) begin
        valid[s] <= '0;
      end
    end else if (en && tg.wrEn) begin
      valid[tg.lkSet][tg.wrWay] <= tg.wrValid;
      tags[tg.lkSet][tg.wrWay]  <= tg.wrTag;
    end
  end

endmodule

`default_nettype wire

// ### hw/esf_filter.sv
// External snoop filter: tracks master lines and filters snoops
`default_nettype none

module esf_filter import esf_pkg::*; #(
  parameter int SETS  = CACHE_SETS,
  parameter int WAYS  = CACHE_WAYS,
  parameter int EXTRA = EXTRA_WAYS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              en,
  // Observed master transactions
  input  wire logic              obsValid,
  output logic                   obsReady,
  input  wire logic              obsWrite,
  input  wire logic [3:0]        obsSnoop,
  input  wire logic [1:0]        obsDomain,
  input  wire logic [ADDR_W-1:0] obsAddr,
  // Snoops from the interconnect
  input  wire logic              snpValid,
  output logic                   snpReady,
  input  wire logic [ADDR_W-1:0] snpAddr,
  input  wire logic [3:0]        snpType,
  output logic                   respValid,
  input  wire logic              respReady,
  output logic [RESP_W-1:0]      resp,
  // Snoops toward the master
  output logic                   fwdValid,
  input  wire logic              fwdReady,
  output logic [ADDR_W-1:0]      fwdAddr,
  output logic [3:0]             fwdType,
  input  wire logic              mstRespValid,
  output logic                   mstRespReady,
  input  wire logic [RESP_W-1:0] mstResp
);

  localparam int NWAYS = WAYS + EXTRA;
  localparam int IDXW  = $clog2(SETS);
  localparam int WAYW  = $clog2(NWAYS);
  localparam int TAGW  = ADDR_W - LINE_OFS - IDXW;

  // ==========================================================
  // Tag store
  esf_tag_if #(.IDXW(IDXW), .TAGW(TAGW), .WAYW(WAYW)) tg ();

  esf_tag_store #(
    .SETS  (SETS),
    .NWAYS (NWAYS),
    .TAGW  (TAGW),
    .WAYW  (WAYW)
  ) u_store (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (en),
    .tg    (tg.store)
  );

  // ==========================================================
  // State
  esf_state_t        state;
  esf_state_t        next_state;
  logic [ADDR_W-1:0] snpAddrQ;
  logic [ADDR_W-1:0] next_snpAddrQ;
  logic [3:0]        snpTypeQ;
  logic [3:0]        next_snpTypeQ;
  logic [ADDR_W-1:0] pendAddr;
  logic [ADDR_W-1:0] next_pendAddr;
  logic [WAYW-1:0]   vicWay;
  logic [WAYW-1:0]   next_vicWay;
  logic [WAYW-1:0]   rrPtr;
  logic [WAYW-1:0]   next_rrPtr;
  logic [RESP_W-1:0] respQ;
  logic [RESP_W-1:0] next_respQ;
  logic [ADDR_W-1:0] fwdAddrQ;
  logic [ADDR_W-1:0] next_fwdAddrQ;
  logic [3:0]        fwdTypeQ;
  logic [3:0]        next_fwdTypeQ;

  logic [ADDR_W-1:0] lkAddr;
  logic [ADDR_W-1:0] vicAddr;
  esf_kind_t         obsKind;
  logic              obsFire;
  logic              mstFire;

  // ==========================================================
  // Lookup address follows the job in hand
  always_comb begin
    case (state)
      ST_IDLE: lkAddr = obsAddr;
      ST_LOOK: lkAddr = snpAddrQ;
      ST_FWD:  lkAddr = snpAddrQ;
      ST_WAIT: lkAddr = snpAddrQ;
      ST_RESP: lkAddr = snpAddrQ;
      default: lkAddr = pendAddr;
    endcase
  end

  assign tg.lkSet = lkAddr[LINE_OFS +: IDXW];
  assign tg.lkTag = lkAddr[ADDR_W-1 -: TAGW];
  assign tg.rdWay = rrPtr;
  assign vicAddr  = {tg.rdTag, tg.lkSet, {LINE_OFS{1'b0}}};

  // ==========================================================
  // Handshakes; snoops take priority over observation
  assign snpReady     = en && (state == ST_IDLE);
  assign obsReady     = en && (state == ST_IDLE) && !snpValid;
  assign obsFire      = obsValid && obsReady;
  assign obsKind      = esf_classify(obsWrite, obsSnoop, obsDomain);
  assign fwdValid     = en && ((state == ST_FWD) || (state == ST_VFWD));
  assign fwdAddr      = fwdAddrQ;
  assign fwdType      = fwdTypeQ;
  assign mstRespReady = en && ((state == ST_WAIT) || (state == ST_VWAIT));
  assign mstFire      = mstRespValid && mstRespReady;
  assign respValid    = en && (state == ST_RESP);
  assign resp         = respQ;

  // ==========================================================
  // Control next state
  always_comb begin
    next_state    = state;
    next_snpAddrQ = snpAddrQ;
    next_snpTypeQ = snpTypeQ;
    next_pendAddr = pendAddr;
    next_vicWay   = vicWay;
    next_rrPtr    = rrPtr;
    next_respQ    = respQ;
    next_fwdAddrQ = fwdAddrQ;
    next_fwdTypeQ = fwdTypeQ;
    tg.wrEn       = 1'b0;
    tg.wrWay      = tg.hitWay;
    tg.wrValid    = 1'b0;
    tg.wrTag      = tg.lkTag;
    case (state)
      ST_IDLE: begin
        if (snpValid && en) begin
          next_snpAddrQ = snpAddr;
          next_snpTypeQ = snpType;
          next_state    = ST_LOOK;
        end else if (obsFire) begin
          case (obsKind)
            K_ALLOC: begin
              // Already tracked lines are not entered twice
              if (!tg.hit && tg.freeValid) begin
                tg.wrEn    = 1'b1;
                tg.wrWay   = tg.freeWay;
                tg.wrValid = 1'b1;
              end else if (!tg.hit) begin
                // Set full: back-snoop a victim first
                next_pendAddr = obsAddr;
                next_vicWay   = rrPtr;
                next_fwdAddrQ = vicAddr;
                next_fwdTypeQ = CLEAN_INVALID;
                next_state    = ST_VFWD;
              end
            end
            K_EVICT: begin
              if (tg.hit) begin
                tg.wrEn    = 1'b1;
                tg.wrValid = 1'b0;
              end
            end
            default: begin
              // Keep and non-snooping kinds write nothing
            end
          endcase
        end
      end
      ST_LOOK: begin
        if (en) begin
          if (tg.hit) begin
            next_fwdAddrQ = snpAddrQ;
            next_fwdTypeQ = snpTypeQ;
            next_state    = ST_FWD;
          end else begin
            next_respQ = RESP_MISS;
            next_state = ST_RESP;
          end
        end
      end
      ST_FWD: begin
        if (en && fwdReady) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mstFire) begin
          next_respQ = mstResp;
          // Line is kept only while the master reports it shared
          if (!mstResp[ISSHARED_BIT] && tg.hit) begin
            tg.wrEn    = 1'b1;
            tg.wrValid = 1'b0;
          end
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        if (en && respReady) begin
          next_state = ST_IDLE;
        end
      end
      ST_VFWD: begin
        if (en && fwdReady) begin
          next_state = ST_VWAIT;
        end
      end
      ST_VWAIT: begin
        if (mstFire) begin
          // Victim way is overwritten by the pending line
          tg.wrEn    = 1'b1;
          tg.wrWay   = vicWay;
          tg.wrValid = 1'b1;
          next_rrPtr = (rrPtr == WAYW'(NWAYS - 1)) ? '0 : rrPtr + 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      snpAddrQ <= '0;
      snpTypeQ <= 4'h0;
      pendAddr <= '0;
      vicWay   <= '0;
      rrPtr    <= '0;
      respQ    <= RESP_MISS;
      fwdAddrQ <= '0;
      fwdTypeQ <= 4'h0;
    end else if (en) begin
      state    <= next_state;
      snpAddrQ <= next_snpAddrQ;
      snpTypeQ <= next_snpTypeQ;
      pendAddr <= next_pendAddr;
      vicWay   <= next_vicWay;
      rrPtr    <= next_rrPtr;
      respQ    <= next_respQ;
      fwdAddrQ <= next_fwdAddrQ;
      fwdTypeQ <= next_fwdTypeQ;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_snoop_hit;
    en && (state == ST_LOOK) && tg.hit;
  endsequence

  sequence s_snoop_miss;
    en && (state == ST_LOOK) && !tg.hit;
  endsequence

  sequence s_alloc_full;
    obsFire && (obsKind == K_ALLOC) && !tg.hit && !tg.freeValid;
  endsequence

  a_alloc_marks: assert property (
    obsFire && (obsKind == K_ALLOC) && !tg.hit && tg.freeValid
      |-> tg.wrEn && tg.wrValid && (tg.wrWay == tg.freeWay))
    else $error("allocating transaction not recorded");

  a_keep_nochange: assert property (
    obsFire && (obsKind == K_KEEP) |-> !tg.wrEn ##1 (state == ST_IDLE))
    else $error("non-allocating transaction changed tracking");

  a_evict_clears: assert property (
    obsFire && (obsKind == K_EVICT) && tg.hit |-> tg.wrEn && !tg.wrValid)
    else $error("evicting transaction left line tracked");

  a_nosnoop_skip: assert property (
    obsFire && (obsKind == K_NONE) |-> !tg.wrEn)
    else $error("non-snooping access was tracked");

  a_no_dup: assert property (
    obsFire && (obsKind == K_ALLOC) && tg.hit |-> !tg.wrEn ##1 !fwdValid)
    else $error("duplicate entry for a tracked line");

  a_miss_local: assert property (
    s_snoop_miss |=> (respValid || !en) && (resp == RESP_MISS) && !fwdValid)
    else $error("untracked snoop not answered locally");

  a_hit_forward: assert property (
    s_snoop_hit |=> (fwdValid || !en) && (fwdAddr == snpAddrQ) && (fwdType == snpTypeQ))
    else $error("tracked snoop not forwarded");

  a_shared_drop: assert property (
    mstFire && (state == ST_WAIT) && tg.hit && !mstResp[ISSHARED_BIT]
      |-> tg.wrEn && !tg.wrValid ##1 (respValid || !en) && (resp == $past(mstResp)))
    else $error("unshared snoop response kept line");

  a_shared_keep: assert property (
    mstFire && (state == ST_WAIT) && mstResp[ISSHARED_BIT] |-> !tg.wrEn)
    else $error("shared snoop response dropped line");

  a_victim_snoop: assert property (
    s_alloc_full |=> (fwdValid || !en) && (fwdType == CLEAN_INVALID) && (state == ST_VFWD))
    else $error("full set did not issue back-snoop");

  a_resp_hold: assert property (
    respValid && !respReady |=> (respValid || !en) && $stable(resp))
    else $error("snoop answer dropped before acceptance");

endmodule

`default_nettype wire

// ### dv/esf_master_model.sv
// Behavioural cached master answering snoops forwarded by the filter
`default_nettype none

module esf_master_model import esf_pkg::*; (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              shared,
  input  wire logic              fwdValid,
  output logic                   fwdReady,
  input  wire logic [ADDR_W-1:0] fwdAddr,
  input  wire logic [3:0]        fwdType,
  output logic                   mstRespValid,
  input  wire logic              mstRespReady,
  output logic [RESP_W-1:0]      mstResp
);
  timeunit 1ns;
  timeprecision 1ps;

  int   delay = 0;
  logic pending = 1'b0;

  initial begin
    fwdReady = 1'b0;
    mstRespValid = 1'b0;
    mstResp = 5'h00;
  end

  // ==========================================================
  // Stalls on accept, answers after 1..4 idle cycles
  always @(posedge clk) begin
    fwdReady <= ($urandom % 3) != 0;
    if (!rst_n) begin
      mstRespValid <= 1'b0;
      pending <= 1'b0;
    end else if (mstRespValid) begin
      if (mstRespReady) begin
        mstRespValid <= 1'b0;
        // Released response no longer shows the last value
        mstResp <= ~mstResp;
      end
    end else if (pending) begin
      if (delay == 0) begin
        mstRespValid <= 1'b1;
        mstResp <= {1'b0, shared, 3'h0};
        pending <= 1'b0;
      end else begin
        delay <= delay - 1;
      end
    end else if (fwdValid && fwdReady) begin
      pending <= 1'b1;
      delay <= $urandom % 4;
    end
  end
endmodule

`default_nettype wire

// ### dv/test_esf_filter.sv
// Self-checking testbench of the external snoop filter
`default_nettype none

module test_esf_filter import esf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [3:0] t; logic [31:0] a; logic chkA;} esf_fwd_exp_t;

  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, shared = 1'b0;
  logic obsValid = 1'b0, obsReady, obsWrite = 1'b0;
  logic [3:0] obsSnoop = 4'h0, snpType = 4'h0, fwdType;
  logic [1:0] obsDomain = 2'h1;
  logic [31:0] obsAddr = 32'h0, snpAddr = 32'h0, fwdAddr;
  logic snpValid = 1'b0, snpReady, respValid, respReady = 1'b0;
  logic fwdValid, fwdReady, mstRespValid, mstRespReady;
  logic [4:0] resp, mstResp;
  logic [4:0] expResp[$];
  esf_fwd_exp_t expFwd[$];
  int num_errors = 0, compares = 0, respSeen = 0;
  logic [31:0] a, b, lines[5];

  localparam logic [3:0] ALLOC[6] = '{RD_CLEAN, RD_NOTSHDIRTY, RD_SHARED, RD_UNIQUE,
                                      CLEAN_UNIQUE, MAKE_UNIQUE};
  localparam logic [4:0] EVC[5] = '{{1'b0, CLEAN_INVALID}, {1'b0, MAKE_INVALID},
                                    {2'b10, WR_BACK}, {2'b10, WR_EVICT_ONLY}, {2'b10, WR_EVICT}};
  localparam logic [4:0] KEEP[5] = '{{1'b0, RD_NOSNOOP_ONCE}, {1'b0, CLEAN_SHARED},
                                     {2'b10, WR_NOSNOOP_UNIQUE}, {2'b10, WR_LINE_UNIQUE},
                                     {2'b10, WR_CLEAN}};

  always #10 clk = ~clk;

  esf_filter #(.SETS(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .en(en), .obsValid(obsValid), .obsReady(obsReady),
    .obsWrite(obsWrite), .obsSnoop(obsSnoop), .obsDomain(obsDomain), .obsAddr(obsAddr),
    .snpValid(snpValid), .snpReady(snpReady), .snpAddr(snpAddr), .snpType(snpType),
    .respValid(respValid), .respReady(respReady), .resp(resp), .fwdValid(fwdValid),
    .fwdReady(fwdReady), .fwdAddr(fwdAddr), .fwdType(fwdType),
    .mstRespValid(mstRespValid), .mstRespReady(mstRespReady), .mstResp(mstResp));

  esf_master_model master_u (
    .clk(clk), .rst_n(rst_n), .shared(shared), .fwdValid(fwdValid), .fwdReady(fwdReady),
    .fwdAddr(fwdAddr), .fwdType(fwdType), .mstRespValid(mstRespValid),
    .mstRespReady(mstRespReady), .mstResp(mstResp));

  // ==========================================================
  // Checking
  task automatic fail(input string msg);
    num_errors++;
    $display("ERROR %0t %s", $time, msg);
  endtask

  task automatic checkResp(input logic [4:0] e);
    compares++;
    if (resp !== e) fail($sformatf("answer %h expected %h", resp, e));
  endtask

  task automatic checkFwd(input esf_fwd_exp_t e);
    compares++;
    if (fwdType !== e.t || (e.chkA && fwdAddr !== e.a)) begin
      fail($sformatf("forward %h/%h expected %h/%h", fwdType, fwdAddr, e.t, e.a));
    end
  endtask

  always @(posedge clk) begin
    respReady <= $urandom % 2;
    if (rst_n && respValid && respReady) begin
      respSeen++;
      if (expResp.size() == 0) fail("unexpected snoop answer");
      else checkResp(expResp.pop_front());
    end
    if (rst_n && fwdValid && fwdReady) begin
      if (expFwd.size() == 0) fail("unexpected forwarded snoop");
      else checkFwd(expFwd.pop_front());
    end
  end

  // ==========================================================
  // Stimulus
  function automatic logic [31:0] ln(input int s, input int k);
    return {16'($urandom), 8'(k), 2'(s), 6'h00};
  endfunction

  function automatic logic [1:0] dm();
    return 2'h1 + 2'($urandom % 2);
  endfunction

  task automatic obs(input logic [4:0] c, input logic [1:0] d, input logic [31:0] ad);
    @(posedge clk);
    obsValid <= 1'b1;
    obsWrite <= c[4];
    obsSnoop <= c[3:0];
    obsDomain <= d;
    obsAddr <= ad | 32'($urandom % 64);
    for (int i = 0; i < 500; i++) begin
      @(posedge clk);
      if (obsReady) break;
      if (i == 499) fail("observed transaction never taken");
    end
    obsValid <= 1'b0;
  endtask

  task automatic snoop(input logic [31:0] ad, input logic fwd, input logic sh);
    logic [3:0] t;
    int n;
    t = 4'($urandom);
    n = respSeen + 1;
    if (fwd) expFwd.push_back('{t, ad, 1'b1});
    expResp.push_back(fwd ? {1'b0, sh, 3'h0} : 5'h00);
    @(posedge clk);
    shared <= sh;
    snpValid <= 1'b1;
    snpAddr <= ad;
    snpType <= t;
    for (int i = 0; i < 500; i++) begin
      @(posedge clk);
      if (snpReady) break;
      if (i == 499) fail("snoop never taken");
    end
    snpValid <= 1'b0;
    for (int i = 0; i < 500 && respSeen < n; i++) @(posedge clk);
    if (respSeen < n) fail("snoop answer missing");
  endtask

  task automatic endTest(input string name);
    $display("test %s done, errors %0d", name, num_errors);
  endtask

  task automatic conclude;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400us;
    fail("timeout");
    conclude();
  end

  initial begin
    void'($urandom(34319));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ALLOC[i]) begin
      a = ln(0, i);
      obs({1'b0, ALLOC[i]}, dm(), a);
      snoop(a, 1'b1, 1'b1);
      obs({2'b10, WR_EVICT_ONLY}, dm(), a);
      snoop(a, 1'b0, 1'b0);
    end
    endTest("allocate");
    foreach (EVC[i]) begin
      a = ln(1, i);
      obs({1'b0, RD_UNIQUE}, dm(), a);
      obs(EVC[i], dm(), a);
      snoop(a, 1'b0, 1'b0);
    end
    endTest("evict");
    a = ln(2, 0);
    obs({1'b0, RD_CLEAN}, dm(), a);
    foreach (KEEP[i]) begin
      b = ln(2, 10 + i);
      obs(KEEP[i], dm(), b);
      snoop(b, 1'b0, 1'b0);
      obs(KEEP[i], dm(), a);
      snoop(a, 1'b1, 1'b1);
    end
    obs({2'b10, WR_BACK}, dm(), a);
    endTest("keep");
    for (int i = 0; i < 4; i++) begin
      b = ln(3, i);
      obs({i[0], 4'h0}, i[1] ? DOM_SYS : DOM_NONSH, b);
      snoop(b, 1'b0, 1'b0);
    end
    endTest("nosnoop");
    a = ln(0, 50);
    obs({1'b0, RD_SHARED}, dm(), a);
    snoop(a, 1'b1, 1'b0);
    snoop(a, 1'b0, 1'b0);
    endTest("isshared");
    foreach (lines[k]) lines[k] = ln(1, 60 + k);
    obs({1'b0, RD_SHARED}, dm(), lines[0]);
    obs({1'b0, RD_UNIQUE}, dm(), lines[0]);
    for (int k = 1; k < 5; k++) obs({1'b0, RD_CLEAN}, dm(), lines[k]);
    foreach (lines[k]) snoop(lines[k], 1'b1, 1'b1);
    expFwd.push_back('{CLEAN_INVALID, 32'h0, 1'b0});
    b = ln(1, 70);
    obs({1'b0, MAKE_UNIQUE}, dm(), b);
    snoop(b, 1'b1, 1'b1);
    endTest("capacity");
    en <= 1'b0;
    fork
      snoop(b, 1'b1, 1'b1);
      begin
        repeat (4) @(posedge clk);
        compares++;
        if (snpReady !== 1'b0) fail("snoop taken while enable low");
        en <= 1'b1;
      end
    join
    endTest("enable");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    snoop(b, 1'b0, 1'b0);
    endTest("reset");
    compares++;
    if (expResp.size() != 0 || expFwd.size() != 0) fail("expected results left over");
    conclude();
  end
endmodule

`default_nettype wire
